/* core/flash_status_and_sector_guard.sv */
// serial command front end: rewrite sequencing, status readout, protection
// assumes sck stops while cs_n is high and array handshake on core_clk
`timescale 1ns/1ps
module flash_status_and_sector_guard
	import flash_guard_pkg::*;
#(
	parameter logic [3:0] DENSITY_CODE = 4'h5 // arbitrary value
) (
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         por_n,
	input  wire logic         sck,
	input  wire logic         cs_n,
	input  wire logic         si,
	output logic              so,
	output logic              so_oe,
	input  wire logic         wp_n,
	output logic              rdy_busy,
	output logic              arr_start,
	output arr_kind_t         arr_kind,
	output logic [PAGE_W-1:0] arr_page,
	output logic              arr_buf2,
	input  wire logic         arr_done,
	input  wire logic         arr_mismatch,
	input  wire logic [127:0] sector_flags
);
	// link side
	logic         first_ff;
	logic [7:0]   cnt_ff;
	logic [2:0]   phase_ff;
	logic [31:0]  word_ff;
	logic [7:0]   op_ff;
	logic [7:0]   stat_l1_ff;
	logic [7:0]   stat_l2_ff;
	logic [127:0] prot_l1_ff;
	logic [127:0] prot_l2_ff;
	logic [7:0]   snap_ff;
	logic         so_ff;
	logic         so_oe_ff;
	logic [7:0]   pidx;
	// core side
	logic         cs_s1_ff;
	logic         cs_s2_ff;
	logic         cs_s3_ff;
	logic         wp_s1_ff;
	logic         wp_s2_ff;
	logic [3:0]   filt_ff;
	logic         hw_prot_ff;
	logic         sw_prot_ff;
	logic         prot_any;
	logic [127:0] prot_ff;
	seq_state_t   state_ff;
	logic         rdy_ff;
	logic         comp_ff;
	logic [7:0]   stat_ff;
	logic         arr_start_ff;
	arr_kind_t    arr_kind_ff;
	logic [PAGE_W-1:0] arr_page_ff;
	logic         arr_buf2_ff;
	logic         frame_end;
	logic         is_on;
	logic         is_off;
	logic [7:0]   cmd_op;
	logic [PAGE_W-1:0] cmd_page;
	logic [3:0]   cmd_sector;
	logic         nxt_valid;
	logic         nxt_rw;
	logic         nxt_write;
	logic         nxt_buf2;
	arr_kind_t    nxt_kind;
	logic         flagged;
	logic         blocked;
	logic         launch;

	// frame start marker, preset while deselected
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			first_ff <= 1'b1;
		end else begin
			first_ff <= 1'b0;
		end
	end

	// bit count and first command word of the frame
	always_ff @(posedge sck) begin
		if (first_ff) begin
			cnt_ff   <= 8'h01;
			phase_ff <= 3'h1;
			word_ff  <= {31'h0, si};
		end else begin
			if (cnt_ff != CNT_MAX) begin
				cnt_ff <= cnt_ff + 8'h01;
			end
			phase_ff <= phase_ff + 3'h1;
			if (cnt_ff < CMD_BITS) begin
				word_ff <= {word_ff[30:0], si};
			end
		end
	end

	// opcode latched at the eighth bit
	always_ff @(posedge sck) begin
		if (!first_ff && cnt_ff == 8'h07) begin
			op_ff <= {word_ff[6:0], si};
		end
	end

	// status and protection contents into the link domain
	always_ff @(posedge sck) begin
		stat_l1_ff <= stat_ff;
		stat_l2_ff <= stat_l1_ff;
		prot_l1_ff <= prot_ff;
		prot_l2_ff <= prot_l1_ff;
	end

	// coherent copy of the status byte per repetition
	always_ff @(negedge sck) begin
		if (phase_ff == 3'h0) begin
			snap_ff <= stat_l2_ff;
		end
	end

	assign pidx = cnt_ff - PREG_START_BIT;

	// serial output, launched on the falling edge
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so_ff    <= 1'b0;
			so_oe_ff <= 1'b0;
		end else if (cnt_ff >= STAT_START_BIT && op_ff == OP_STATUS) begin
			so_oe_ff <= 1'b1;
			if (phase_ff == 3'h0) begin
				so_ff <= stat_l2_ff[7];
			end else begin
				so_ff <= snap_ff[3'h7 - phase_ff];
			end
		end else if (word_ff == SEQ_PROT_READ && cnt_ff >= PREG_START_BIT
				&& cnt_ff < PREG_END_BIT) begin
			so_oe_ff <= 1'b1;
			so_ff    <= prot_l2_ff[{pidx[6:3], ~pidx[2:0]}];
		end else begin
			so_ff    <= 1'b0;
			so_oe_ff <= 1'b0;
		end
	end

	assign so    = so_ff;
	assign so_oe = so_oe_ff;

	// select rise seen in the core domain
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
		end else begin
			cs_s1_ff <= cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
		end
	end

	assign frame_end = cs_s2_ff && !cs_s3_ff;

	// write protect pin sync; a floating pin is pulled high
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wp_s1_ff <= 1'b1;
			wp_s2_ff <= 1'b1;
		end else begin
			wp_s1_ff <= wp_n;
			wp_s2_ff <= wp_s1_ff;
		end
	end

	// glitch filter: level must hold before the state follows
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			filt_ff    <= 4'h0;
			hw_prot_ff <= 1'b0;
		end else if (!wp_s2_ff != hw_prot_ff) begin
			if (filt_ff == 4'(WP_FILTER_CYC - 1)) begin
				filt_ff    <= 4'h0;
				hw_prot_ff <= !wp_s2_ff;
			end else begin
				filt_ff <= filt_ff + 4'h1;
			end
		end else begin
			filt_ff <= 4'h0;
		end
	end

	assign is_on  = frame_end && cnt_ff == CMD_BITS && word_ff == SEQ_PROT_ON;
	assign is_off = frame_end && cnt_ff == CMD_BITS
		&& word_ff == SEQ_PROT_OFF;

	// software enable: cleared at power up or by the disable sequence, not by rst_n
	always_ff @(posedge core_clk) begin
		if (!por_n) begin
			sw_prot_ff <= 1'b0;
		end else if (is_on) begin
			sw_prot_ff <= 1'b1;
		end else if (is_off && !hw_prot_ff) begin
			sw_prot_ff <= 1'b0;
		end
	end

	assign prot_any = sw_prot_ff || hw_prot_ff;

	// sixteen protection bytes from nonvolatile store
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prot_ff <= 128'h0;
		end else begin
			prot_ff <= sector_flags;
		end
	end

	assign cmd_op     = word_ff[31:24];
	assign cmd_page   = word_ff[PAGE_LSB +: PAGE_W];
	assign cmd_sector = cmd_page[SECTOR_LSB +: 4];

	// command decode
	always_comb begin
		nxt_valid = 1'b1;
		nxt_rw    = 1'b0;
		nxt_write = 1'b1;
		nxt_buf2  = 1'b0;
		nxt_kind  = K_PROG;
		case (cmd_op)
			OP_REWRITE_B1, OP_REWRITE_B2: begin
				nxt_rw   = 1'b1;
				nxt_kind = K_XFER;
				nxt_buf2 = cmd_op == OP_REWRITE_B2;
			end
			OP_XFER_B1, OP_XFER_B2: begin
				nxt_write = 1'b0;
				nxt_kind  = K_XFER;
				nxt_buf2  = cmd_op == OP_XFER_B2;
			end
			OP_CMP_B1, OP_CMP_B2: begin
				nxt_write = 1'b0;
				nxt_kind  = K_COMPARE;
				nxt_buf2  = cmd_op == OP_CMP_B2;
			end
			OP_PROG_B1, OP_PROG_B2: begin
				nxt_buf2 = cmd_op == OP_PROG_B2;
			end
			OP_THRU_B1, OP_THRU_B2: begin
				nxt_kind = K_PROG_ERASE;
				nxt_buf2 = cmd_op == OP_THRU_B2;
			end
			OP_PAGE_ERASE: begin
				nxt_kind = K_PAGE_ERASE;
			end
			OP_BLOCK_ERASE: begin
				nxt_kind = K_BLOCK_ERASE;
			end
			default: begin
				nxt_valid = 1'b0;
				nxt_write = 1'b0;
			end
		endcase
	end

	// sector 0 splits into pages 0-7 and the rest
	assign flagged = (cmd_sector == 4'h0)
		? (cmd_page < 13'h0008 ? prot_ff[7] : prot_ff[5])
		: prot_ff[{cmd_sector, 3'h7}];
	assign blocked = nxt_write && prot_any && flagged;
	assign launch  = frame_end && cnt_ff >= CMD_BITS && nxt_valid
		&& !blocked && state_ff == ST_IDLE;

	// operation sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (launch) begin
						state_ff <= nxt_rw ? ST_RW_XFER : ST_SINGLE;
					end
				end
				ST_SINGLE: begin
					if (arr_done) begin
						state_ff <= ST_IDLE;
					end
				end
				ST_RW_XFER: begin
					if (arr_done) begin
						state_ff <= ST_RW_PROG;
					end
				end
				ST_RW_PROG: begin
					if (arr_done) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// array request
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			arr_start_ff <= 1'b0;
			arr_kind_ff  <= K_XFER;
			arr_page_ff  <= '0;
			arr_buf2_ff  <= 1'b0;
		end else begin
			arr_start_ff <= launch || (state_ff == ST_RW_XFER && arr_done);
			if (launch) begin
				arr_kind_ff <= nxt_kind;
				arr_page_ff <= cmd_page;
				arr_buf2_ff <= nxt_buf2;
			end else if (state_ff == ST_RW_XFER && arr_done) begin
				arr_kind_ff <= K_PROG_ERASE;
			end
		end
	end

	// compare result and status byte
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			comp_ff <= 1'b0;
		end else if (state_ff == ST_SINGLE && arr_done
				&& arr_kind_ff == K_COMPARE) begin
			comp_ff <= arr_mismatch;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdy_ff  <= 1'b1;
			stat_ff <= STATUS_RESET | {2'b00, DENSITY_CODE, 2'b00};
		end else begin
			rdy_ff  <= state_ff == ST_IDLE;
			// bit 0 reserved, driven as zero
			stat_ff <= {state_ff == ST_IDLE, comp_ff, DENSITY_CODE,
				prot_any, 1'b0};
		end
	end

	assign rdy_busy  = rdy_ff;
	assign arr_start = arr_start_ff;
	assign arr_kind  = arr_kind_ff;
	assign arr_page  = arr_page_ff;
	assign arr_buf2  = arr_buf2_ff;

	// checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_xfer_done;
		state_ff == ST_RW_XFER && arr_done;
	endsequence
	sequence s_prog_start;
		state_ff == ST_RW_PROG && arr_start_ff
			&& arr_kind_ff == K_PROG_ERASE;
	endsequence
	property p_rewrite_chain;
		s_xfer_done |=> s_prog_start;
	endproperty
	a_rewrite_chain: assert property (p_rewrite_chain)
		else $error("rewrite did not chain into program");

	property p_busy_pin;
		state_ff != ST_IDLE |=> !rdy_ff && !stat_ff[ST_RDY_BIT];
	endproperty
	a_busy_pin: assert property (p_busy_pin)
		else $error("busy not reported");

	property p_ready;
		state_ff == ST_IDLE ##1 state_ff == ST_IDLE |-> rdy_ff
			&& stat_ff[ST_RDY_BIT];
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready not reported when idle");

	property p_prot_on;
		is_on && por_n |=> sw_prot_ff;
	endproperty
	a_prot_on: assert property (p_prot_on)
		else $error("enable sequence ignored");

	property p_prot_off;
		is_off && !hw_prot_ff && por_n |=> !sw_prot_ff;
	endproperty
	a_prot_off: assert property (p_prot_off)
		else $error("disable sequence ignored");

	property p_wp_hold;
		hw_prot_ff && sw_prot_ff && por_n |=> sw_prot_ff;
	endproperty
	a_wp_hold: assert property (p_wp_hold)
		else $error("protection dropped while pin asserted");

	property p_reset_keeps;
		@(posedge core_clk) disable iff (!por_n)
		!rst_n |=> $stable(sw_prot_ff);
	endproperty
	a_reset_keeps: assert property (p_reset_keeps)
		else $error("reset pin changed software protection");

	property p_block;
		frame_end && nxt_valid && blocked |=> !arr_start_ff;
	endproperty
	a_block: assert property (p_block)
		else $error("write started on protected sector");

	property p_filter;
		$rose(hw_prot_ff) |-> $past(wp_s2_ff, 1) == 1'b0
			&& $past(wp_s2_ff, 5) == 1'b0;
	endproperty
	a_filter: assert property (p_filter)
		else $error("pin protection followed a glitch");

	property p_prot_bit;
		1'b1 |=> stat_ff[ST_PROT_BIT] == $past(sw_prot_ff || hw_prot_ff);
	endproperty
	a_prot_bit: assert property (p_prot_bit)
		else $error("protect status bit wrong");

	property p_compare;
		state_ff == ST_SINGLE && arr_done && arr_kind_ff == K_COMPARE
			|-> ##2 stat_ff[ST_COMP_BIT] == $past(arr_mismatch, 2);
	endproperty
	a_compare: assert property (p_compare)
		else $error("compare result not reported");
endmodule

/* core/flash_guard_pkg.sv */
// constants, opcodes and types for the flash status and sector guard
// assumes a 25 MHz core clock and a mode 0 serial link clocked by the host
// Contract
// - rewrite: opcode, reserved bit, page, ignored bits
// - rewrite copies page to buffer, programs back
// - status opcode, then status shifts out next clock
// - status byte shifted msb first, one per clock
// - status repeats, fresh contents, while select low
// - top status bit is one when idle
// - busy during every internal array operation
// - status bit one shows protection enabled
// - bits five to two hold fixed density code
// - bit six holds latest compare result
// - bit zero reserved, host ignores it
// - enable sequence takes effect at select rise
// - disable sequence takes effect at select rise
// - write protect pin blocks the disable sequence
// - floating write protect pin means deasserted
// - power cycle clears, reset pin keeps software enable
// - asserted pin refuses writes on flagged sectors
// - write protect input glitch filtered
// - software enable refuses writes on flagged sectors
// - protection register read after 32 ignored clocks
// - sixteen protection bytes, one per sector
package flash_guard_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int WP_FILTER_NS  = 200;
	localparam int WP_FILTER_CYC =
		(WP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] OP_REWRITE_B1    = 8'h58;
	localparam logic [7:0] OP_REWRITE_B2    = 8'h59;
	localparam logic [7:0] OP_STATUS        = 8'hd7;
	localparam logic [7:0] OP_XFER_B1       = 8'h53;
	localparam logic [7:0] OP_XFER_B2       = 8'h55;
	localparam logic [7:0] OP_CMP_B1        = 8'h60;
	localparam logic [7:0] OP_CMP_B2        = 8'h61;
	localparam logic [7:0] OP_PROG_B1       = 8'h88;
	localparam logic [7:0] OP_PROG_B2       = 8'h89;
	localparam logic [7:0] OP_PAGE_ERASE    = 8'h81;
	localparam logic [7:0] OP_BLOCK_ERASE   = 8'h50;
	localparam logic [7:0] OP_THRU_B1       = 8'h82;
	localparam logic [7:0] OP_THRU_B2       = 8'h85;

	localparam logic [31:0] SEQ_PROT_ON   = 32'h3d2a7fa9;
	localparam logic [31:0] SEQ_PROT_OFF  = 32'h3d2a7f9a;
	localparam logic [31:0] SEQ_PROT_READ = 32'h32000000;

	localparam logic [7:0] CMD_BITS       = 8'h20;
	localparam logic [7:0] STAT_START_BIT = 8'h08;
	localparam logic [7:0] PREG_START_BIT = 8'h40;
	localparam logic [7:0] PREG_END_BIT   = 8'hc0;
	localparam logic [7:0] CNT_MAX        = 8'hff;

	localparam int PAGE_LSB   = 10;
	localparam int PAGE_W     = 13;
	localparam int SECTOR_LSB = 9;
	localparam int SECTORS    = 16;
	localparam int ST_RDY_BIT  = 7;
	localparam int ST_COMP_BIT = 6;
	localparam int ST_PROT_BIT = 1;
	localparam logic [7:0] STATUS_RESET = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SINGLE  = 2'b01,
		ST_RW_XFER = 2'b10,
		ST_RW_PROG = 2'b11
	} seq_state_t;

	typedef enum logic [2:0] {
		K_XFER        = 3'b000,
		K_COMPARE     = 3'b001,
		K_PROG        = 3'b010,
		K_PROG_ERASE  = 3'b011,
		K_PAGE_ERASE  = 3'b100,
		K_BLOCK_ERASE = 3'b101
	} arr_kind_t;
endpackage

/* tb/spi_host_model.sv */
// host side serial controller model, mode 0, sck idles low between frames
// assumes the bench calls frame() from one process at a time
`timescale 1ns/1ps
module spi_host_model (
	output logic       sck,
	output logic       cs_n,
	output logic       si,
	input  wire logic  so,
	input  wire logic  so_oe,
	output logic [7:0] rx_byte,
	output logic [7:0] rx_oe,
	output logic       rx_valid
);
	// 48 ns link period, below 25 MHz so no dummy byte is needed
	localparam time HALF = 24;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_oe = 8'h00;
		rx_valid = 1'b0;
	end

	// command word msb first, then whole bytes read back
	task automatic frame(input logic [31:0] w, input int nbits, input int nrd);
		#13;
		cs_n = 1'b0;
		#HALF;
		for (int i = 0; i < nbits; i++) begin
			si = w[31-i];
			#HALF;
			sck = 1'b1;
			#HALF;
			sck = 1'b0;
		end
		for (int b = 0; b < nrd; b++) begin
			for (int i = 0; i < 8; i++) begin
				si = ~si;
				#HALF;
				sck = 1'b1;
				rx_byte = {rx_byte[6:0], so};
				rx_oe = {rx_oe[6:0], so_oe};
				#HALF;
				sck = 1'b0;
			end
			rx_valid = 1'b1;
			#1;
			rx_valid = 1'b0;
		end
		#HALF;
		cs_n = 1'b1;
		si = ~si;
		#(4*HALF);
	endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the flash status and sector guard
// assumes the host model on the link and a behavioural array here
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	import flash_guard_pkg::*;
	localparam logic [3:0] DENS = 4'h9; // arbitrary value
	logic              core_clk, rst_n, por_n, wp_n;
	logic              arr_done, arr_mismatch, mm_next, comp;
	logic [127:0]      sector_flags;
	logic              sck, cs_n, si, so, so_oe, rdy_busy;
	logic              arr_start, arr_buf2, rx_valid;
	arr_kind_t         arr_kind;
	logic [PAGE_W-1:0] arr_page, pg;
	logic [7:0]        rx_byte, rx_oe;
	logic [7:0]        ops[2];
	logic [11:0]       singles[5];
	logic [16:0]       exp_arr[$];
	logic [16:0]       arr_exp;
	logic [15:0]       exp_st[$];
	logic [15:0]       st_exp;
	int                fails, checked, cycles;

	flash_status_and_sector_guard #(.DENSITY_CODE(DENS)) DUT (
		.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n), .sck(sck),
		.cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n),
		.rdy_busy(rdy_busy), .arr_start(arr_start), .arr_kind(arr_kind),
		.arr_page(arr_page), .arr_buf2(arr_buf2), .arr_done(arr_done),
		.arr_mismatch(arr_mismatch), .sector_flags(sector_flags));

	spi_host_model host (
		.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.rx_byte(rx_byte), .rx_oe(rx_oe), .rx_valid(rx_valid));

	always #20 core_clk = ~core_clk;

	// status bytes; bit zero masked, the host ignores it
	always @(posedge rx_valid) begin
		st_exp = exp_st.pop_front();
		`CHK({rx_oe, rx_byte & 8'hfe}, st_exp)
	end

	// array partner: check each request, answer after a random delay
	always @(posedge core_clk) begin
		if (arr_start === 1'b1) begin
			arr_exp = exp_arr.pop_front();
			`CHK({arr_kind, arr_buf2, arr_page}, arr_exp)
			repeat (30 + $urandom % 10) @(posedge core_clk);
			arr_mismatch <= mm_next;
			arr_done <= 1'b1;
			@(posedge core_clk);
			arr_done <= 1'b0;
		end
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic status(input logic rdy, input logic prot, input int n);
		for (int i = 0; i < n; i++)
			exp_st.push_back({8'hff, rdy, comp, DENS, prot, 1'b0});
		host.frame({OP_STATUS, 24'h0}, 8, n);
		cyc(2);
		`CHK(so_oe, 1'b0)
	endtask

	task automatic prot_read;
		repeat (4) exp_st.push_back(16'h0000);
		for (int s = 0; s < SECTORS; s++)
			exp_st.push_back({8'hff, sector_flags[8*s +: 8] & 8'hfe});
		host.frame(SEQ_PROT_READ, 32, 4 + SECTORS);
		cyc(2);
	endtask

	task automatic cmd(input logic [31:0] w);
		host.frame(w, 32, 0);
		cyc(8);
	endtask

	task automatic launch(input logic [7:0] op, input logic go);
		host.frame({op, 1'b0, pg, 10'h0}, 32, 0);
		cyc(10);
		`CHK(rdy_busy, ~go)
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (rdy_busy !== 1'b1 && n < 400) begin
			n++;
			cyc(1);
		end
		`CHK(rdy_busy, 1'b1)
	endtask

	task automatic reset_pulse(input logic por);
		rst_n <= 1'b0;
		por_n <= ~por;
		cyc(4);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		cyc(4);
	endtask

	initial begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		por_n = 1'b0;
		wp_n = 1'b1;
		arr_done = 1'b0;
		arr_mismatch = 1'b0;
		mm_next = 1'b0;
		comp = 1'b0;
		sector_flags = 128'h0;
		pg = '0;
		ops = '{OP_REWRITE_B1, OP_REWRITE_B2};
		singles = '{{OP_XFER_B2, K_XFER, 1'b1},
			{OP_PROG_B1, K_PROG, 1'b0},
			{OP_THRU_B2, K_PROG_ERASE, 1'b1},
			{OP_PAGE_ERASE, K_PAGE_ERASE, 1'b0},
			{OP_BLOCK_ERASE, K_BLOCK_ERASE, 1'b0}};
		void'($urandom(39771));
		cyc(8);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		cyc(3);
		status(1'b1, 1'b0, 3);
		$display("test status readout done");
		cmd(SEQ_PROT_ON);
		status(1'b1, 1'b1, 1);
		wp_n <= 1'b0;
		cmd(SEQ_PROT_OFF);
		wp_n <= 1'b1;
		cyc(10);
		status(1'b1, 1'b1, 1);
		cmd(SEQ_PROT_OFF);
		status(1'b1, 1'b0, 1);
		wp_n <= 1'b0;
		cyc(2);
		wp_n <= 1'b1;
		cyc(10);
		status(1'b1, 1'b0, 1);
		wp_n <= 1'b0;
		cyc(10);
		status(1'b1, 1'b1, 1);
		wp_n <= 1'b1;
		cyc(10);
		cmd(SEQ_PROT_ON);
		reset_pulse(1'b0);
		status(1'b1, 1'b1, 1);
		reset_pulse(1'b1);
		status(1'b1, 1'b0, 1);
		sector_flags <= {$urandom, $urandom, $urandom, $urandom};
		cyc(2);
		prot_read();
		$display("test protection flags done");
		// few rewrites, well inside the endurance window
		foreach (ops[i]) begin
			pg = PAGE_W'($urandom);
			exp_arr.push_back({K_XFER, ops[i][0], pg});
			exp_arr.push_back({K_PROG_ERASE, ops[i][0], pg});
			launch(ops[i], 1'b1);
			status(1'b0, 1'b0, 1);
			wait_ready();
		end
		foreach (singles[i]) begin
			pg = PAGE_W'($urandom);
			exp_arr.push_back({singles[i][3:0], pg});
			launch(singles[i][11:4], 1'b1);
			status(1'b0, 1'b0, 1);
			wait_ready();
		end
		$display("test rewrite done");
		for (int m = 1; m >= 0; m--) begin
			mm_next = m[0];
			exp_arr.push_back({K_COMPARE, 1'b0, pg});
			launch(OP_CMP_B1, 1'b1);
			wait_ready();
			comp = m[0];
			status(1'b1, 1'b0, 1);
		end
		$display("test compare done");
		sector_flags[8*3 +: 8] <= 8'hff;
		cmd(SEQ_PROT_ON);
		pg = {4'h3, 9'($urandom)};
		launch(OP_REWRITE_B2, 1'b0);
		status(1'b1, 1'b1, 1);
		cmd(SEQ_PROT_OFF);
		wp_n <= 1'b0;
		cyc(10);
		launch(OP_REWRITE_B1, 1'b0);
		wp_n <= 1'b1;
		cyc(10);
		exp_arr.push_back({K_XFER, 1'b1, pg});
		exp_arr.push_back({K_PROG_ERASE, 1'b1, pg});
		launch(OP_REWRITE_B2, 1'b1);
		wait_ready();
		`CHK(exp_arr.size() == 0, 1'b1)
		$display("test sector guard done");
		complete_run();
	end
endmodule
